/* hdl/tdp_pkg.sv */
// Summary of operation
// - Every port DMA transfer moves exactly one byte to or from memory.
// - The comparator channel only moves bytes from memory out to the port.
// - The capture channel moves bytes either way, chosen by a port control bit.
// - Capture transfers may be triggered by comparator events through the loop-back.
// - Port bytes are strobed by internal sync or by the timer on-chip event.
// - Bit 5 of the DMA control register picks capture register or port.
// - Bit 4 of the DMA control register picks compare register or port.
// - The timer DMA control register resets to A7h: capture select bit 5 set, compare select bit 4 clear.
// - Output A control bit 1 makes a comparator match raise the on-chip event.
// - Output B control bit 1 makes counter wrap raise the on-chip event.
// - Connection bit 1 loops output A to input A on odd timers.
// - Connection bit 0 loops output A to input A on even timers.
// - Both loop-back connection bits reset to zero.
// - The port control register holds four DMA bits apart from handshake bits.
// - The designated timer's on-chip event drives this port's strobe.
// - Port control bit 4 low enables port DMA; it resets to disabled.
// - Port control bit 3 sets capture direction: 0 drives out, 1 reads in.
// - Port control bit 2 picks strobe: 0 internal sync, 1 on-chip event.
// - Port control bit 1 picks the serving channel: 0 capture, 1 comparator.
package tdp_pkg;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [7:0] IDX_IRQ_DMA_CTRL = 8'hF3;
    localparam logic [7:0] IDX_IO_CONN = 8'hF8;
    localparam logic [7:0] IDX_OUT_A_CTRL = 8'hFC;
    localparam logic [7:0] IDX_OUT_B_CTRL = 8'hFD;
    localparam logic [7:0] IDX_PORT_HS_DMA = 8'hF7;
    localparam logic [7:0] IDX_DMA_ADDR = 8'hF0;
    localparam logic [7:0] IDX_DMA_STATUS = 8'hF1;

    // Field positions.
    localparam int CAPTURE_SOURCE_SELECT_BIT = 5;
    localparam int COMPARE_DEST_SELECT_BIT = 4;
    localparam int MATCH_EVENT_ENABLE_BIT = 1;
    localparam int WRAP_EVENT_ENABLE_BIT = 1;
    localparam int ODD_TIMER_LOOPBACK_BIT = 1;
    localparam int EVEN_TIMER_LOOPBACK_BIT = 0;
    localparam int PORT_DMA_DISABLE_N_BIT = 4;
    localparam int TRANSFER_DIRECTION_BIT = 3;
    localparam int STROBE_SOURCE_SELECT_BIT = 2;
    localparam int CHANNEL_SELECT_BIT = 1;

    // Values after reset.
    localparam logic [7:0] RST_IRQ_DMA_CTRL = 8'hA7;
    localparam logic [7:0] RST_IO_CONN = 8'h00;
    localparam logic [7:0] RST_OUT_A_CTRL = 8'h00;
    localparam logic [7:0] RST_OUT_B_CTRL = 8'h00;
    localparam logic [7:0] RST_PORT_HS_DMA = 8'hFF;
    localparam logic [15:0] RST_DMA_ADDR = 16'h0000;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_READ,
        ST_WRITE
    } tdp_fsm_type;

    typedef struct packed {
        logic [7:0] timer_irq_dma_control;
        logic [7:0] timer_io_connection;
        logic [7:0] output_a_control;
        logic [7:0] output_b_control;
        logic [7:0] port_handshake_dma_control;
        logic [15:0] dma_addr;
        logic [7:0] byte_count;
        tdp_fsm_type fsm;
        logic pend_cmp;
        logic pend_cap;
        logic chan_cmp;
        logic [7:0] master;
        logic [7:0] slave;
        logic [7:0] in_latch;
        logic port_oe;
        logic mem_req;
        logic mem_we;
        logic [15:0] mem_addr;
        logic [7:0] mem_wdata;
        logic onchip_evt;
        logic tin_a;
        logic tin_prev;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } tdp_state_type;

endpackage

/* hdl/tdp_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module tdp_sync #(
    parameter int W = 1
) (
    // Clock, reset and clock enable.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // Data.
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    // The first stage is read only by the second stage.
    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_ff <= '0;
            q_ff <= '0;
        end
        else if (ce)
        begin
            meta_ff <= d;
            q_ff <= meta_ff;
        end
    end

    assign q = q_ff;
endmodule
`default_nettype wire

/* hdl/tdp_timer_dma_port.sv */
`timescale 1ns/1ns
`default_nettype none
module tdp_timer_dma_port #(
    parameter int PADDR_W = 12,
    parameter int TIMER_INDEX = 1
) (
    // Clock, reset and clock enable.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Timer side.
    input wire logic cmp_match,
    input wire logic cmp_wrap,
    input wire logic cmp_dma_req,
    input wire logic cap_sw_req,
    input wire logic timer_output_a,
    output logic timer_input_a,
    output logic onchip_event,
    output logic capture_source_port,
    output logic compare_dest_port,
    // Register file or memory, one byte per transfer.
    output logic mem_req,
    output logic mem_we,
    output logic [15:0] mem_addr,
    output logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    input wire logic mem_ack,
    // Pins.
    input wire logic timer_input_a_pin,
    input wire logic [7:0] port_in,
    output logic [7:0] port_out,
    output logic [7:0] port_oe
);
    tdp_pkg::tdp_state_type state_ff;
    tdp_pkg::tdp_state_type nxt_state;
    logic [7:0] port_sync;
    logic pin_a_sync;
    logic onchip_now;
    logic loop_sel;
    logic dma_on;
    logic cmp_act;
    logic cap_act;
    logic cap_in;
    logic strobe_evt;
    logic cap_edge;
    logic apb_setup;
    logic apb_done;
    logic hit;

    tdp_sync #(
        .W(9)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .d({timer_input_a_pin, port_in}),
        .q({pin_a_sync, port_sync})
    );

    function automatic logic at_index(input logic [PADDR_W-1:0] a, input logic [7:0] idx);
        return a == PADDR_W'({idx, 2'b00});
    endfunction

    always_comb
    begin
        dma_on = !state_ff.port_handshake_dma_control[tdp_pkg::PORT_DMA_DISABLE_N_BIT];
        cmp_act = dma_on
            && state_ff.timer_irq_dma_control[tdp_pkg::COMPARE_DEST_SELECT_BIT]
            && state_ff.port_handshake_dma_control[tdp_pkg::CHANNEL_SELECT_BIT];
        cap_act = dma_on
            && state_ff.timer_irq_dma_control[tdp_pkg::CAPTURE_SOURCE_SELECT_BIT]
            && !state_ff.port_handshake_dma_control[tdp_pkg::CHANNEL_SELECT_BIT];
        cap_in = state_ff.port_handshake_dma_control[tdp_pkg::TRANSFER_DIRECTION_BIT];
        strobe_evt = state_ff.port_handshake_dma_control[tdp_pkg::STROBE_SOURCE_SELECT_BIT];
        onchip_now = (state_ff.output_a_control[tdp_pkg::MATCH_EVENT_ENABLE_BIT] && cmp_match)
            || (state_ff.output_b_control[tdp_pkg::WRAP_EVENT_ENABLE_BIT] && cmp_wrap);
        // Odd timers use the odd loop-back bit, even timers the even one.
        loop_sel = (TIMER_INDEX % 2 == 1)
            ? state_ff.timer_io_connection[tdp_pkg::ODD_TIMER_LOOPBACK_BIT]
            : state_ff.timer_io_connection[tdp_pkg::EVEN_TIMER_LOOPBACK_BIT];
        cap_edge = state_ff.tin_a ^ state_ff.tin_prev;
        apb_setup = psel && penable && !state_ff.pready;
        apb_done = psel && penable && state_ff.pready;
        hit = at_index(paddr, tdp_pkg::IDX_IRQ_DMA_CTRL)
            || at_index(paddr, tdp_pkg::IDX_IO_CONN)
            || at_index(paddr, tdp_pkg::IDX_OUT_A_CTRL)
            || at_index(paddr, tdp_pkg::IDX_OUT_B_CTRL)
            || at_index(paddr, tdp_pkg::IDX_PORT_HS_DMA)
            || at_index(paddr, tdp_pkg::IDX_DMA_ADDR)
            || at_index(paddr, tdp_pkg::IDX_DMA_STATUS);
    end

    always_comb
    begin
        nxt_state = state_ff;
        // The event output is what strobes this port's latches.
        nxt_state.onchip_evt = onchip_now;
        // An output toggle looped back here starts capture transfers.
        nxt_state.tin_a = loop_sel ? timer_output_a : pin_a_sync;
        nxt_state.tin_prev = state_ff.tin_a;
        // A new request in the cycle its pending flag is taken is kept.
        nxt_state.pend_cmp = state_ff.pend_cmp || (cmp_act && cmp_dma_req);
        nxt_state.pend_cap = state_ff.pend_cap || (cap_act && (cap_edge || cap_sw_req));
        nxt_state.port_oe = cmp_act || (cap_act && !cap_in);
        if (strobe_evt && onchip_now)
        begin
            nxt_state.slave = state_ff.master;
            nxt_state.in_latch = port_sync;
        end
        case (state_ff.fsm)
            tdp_pkg::ST_IDLE:
            begin
                if (state_ff.pend_cmp && cmp_act)
                begin
                    nxt_state.pend_cmp = cmp_act && cmp_dma_req;
                    nxt_state.chan_cmp = 1'b1;
                    nxt_state.mem_req = 1'b1;
                    nxt_state.mem_we = 1'b0;
                    nxt_state.mem_addr = state_ff.dma_addr;
                    nxt_state.fsm = tdp_pkg::ST_READ;
                end
                else if (state_ff.pend_cap && cap_act)
                begin
                    nxt_state.pend_cap = cap_act && (cap_edge || cap_sw_req);
                    nxt_state.chan_cmp = 1'b0;
                    nxt_state.mem_req = 1'b1;
                    nxt_state.mem_we = cap_in;
                    nxt_state.mem_addr = state_ff.dma_addr;
                    nxt_state.mem_wdata = strobe_evt ? state_ff.in_latch : port_sync;
                    nxt_state.fsm = cap_in ? tdp_pkg::ST_WRITE : tdp_pkg::ST_READ;
                end
            end
            tdp_pkg::ST_READ:
            begin
                if (mem_ack)
                begin
                    nxt_state.master = mem_rdata;
                    // Without the event strobe the pins follow at the end of the cycle.
                    if (!strobe_evt)
                    begin
                        nxt_state.slave = mem_rdata;
                    end
                    nxt_state.mem_req = 1'b0;
                    nxt_state.dma_addr = state_ff.dma_addr + 16'h0001;
                    nxt_state.byte_count = state_ff.byte_count + 8'h01;
                    nxt_state.fsm = tdp_pkg::ST_IDLE;
                end
            end
            tdp_pkg::ST_WRITE:
            begin
                if (mem_ack)
                begin
                    nxt_state.mem_req = 1'b0;
                    nxt_state.mem_we = 1'b0;
                    nxt_state.dma_addr = state_ff.dma_addr + 16'h0001;
                    nxt_state.byte_count = state_ff.byte_count + 8'h01;
                    nxt_state.fsm = tdp_pkg::ST_IDLE;
                end
            end
            default:
            begin
                nxt_state.mem_req = 1'b0;
                nxt_state.fsm = tdp_pkg::ST_IDLE;
            end
        endcase
        // One wait state keeps every bus output on a flip-flop.
        nxt_state.pready = apb_setup;
        nxt_state.pslverr = apb_setup && !hit;
        if (apb_setup)
        begin
            nxt_state.prdata = 32'h0000_0000;
            if (at_index(paddr, tdp_pkg::IDX_IRQ_DMA_CTRL))
            begin
                nxt_state.prdata[7:0] = state_ff.timer_irq_dma_control;
            end
            if (at_index(paddr, tdp_pkg::IDX_IO_CONN))
            begin
                nxt_state.prdata[7:0] = state_ff.timer_io_connection;
            end
            if (at_index(paddr, tdp_pkg::IDX_OUT_A_CTRL))
            begin
                nxt_state.prdata[7:0] = state_ff.output_a_control;
            end
            if (at_index(paddr, tdp_pkg::IDX_OUT_B_CTRL))
            begin
                nxt_state.prdata[7:0] = state_ff.output_b_control;
            end
            if (at_index(paddr, tdp_pkg::IDX_PORT_HS_DMA))
            begin
                nxt_state.prdata[7:0] = state_ff.port_handshake_dma_control;
            end
            if (at_index(paddr, tdp_pkg::IDX_DMA_ADDR))
            begin
                nxt_state.prdata[15:0] = state_ff.dma_addr;
            end
            if (at_index(paddr, tdp_pkg::IDX_DMA_STATUS))
            begin
                nxt_state.prdata[15:0] = {state_ff.byte_count, 4'h0, state_ff.port_oe,
                    state_ff.mem_req, state_ff.pend_cap, state_ff.pend_cmp};
            end
        end
        // Software writes land last so they override a DMA address step.
        if (apb_done && pwrite && hit && pstrb[0])
        begin
            if (at_index(paddr, tdp_pkg::IDX_IRQ_DMA_CTRL))
            begin
                nxt_state.timer_irq_dma_control = pwdata[7:0];
            end
            if (at_index(paddr, tdp_pkg::IDX_IO_CONN))
            begin
                nxt_state.timer_io_connection = pwdata[7:0];
            end
            if (at_index(paddr, tdp_pkg::IDX_OUT_A_CTRL))
            begin
                nxt_state.output_a_control = pwdata[7:0];
            end
            if (at_index(paddr, tdp_pkg::IDX_OUT_B_CTRL))
            begin
                nxt_state.output_b_control = pwdata[7:0];
            end
            if (at_index(paddr, tdp_pkg::IDX_PORT_HS_DMA))
            begin
                nxt_state.port_handshake_dma_control = pwdata[7:0];
            end
            if (at_index(paddr, tdp_pkg::IDX_DMA_ADDR) && pstrb[1])
            begin
                nxt_state.dma_addr = pwdata[15:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff <= '0;
            state_ff.timer_irq_dma_control <= tdp_pkg::RST_IRQ_DMA_CTRL;
            state_ff.timer_io_connection <= tdp_pkg::RST_IO_CONN;
            state_ff.output_a_control <= tdp_pkg::RST_OUT_A_CTRL;
            state_ff.output_b_control <= tdp_pkg::RST_OUT_B_CTRL;
            state_ff.port_handshake_dma_control <= tdp_pkg::RST_PORT_HS_DMA;
            state_ff.dma_addr <= tdp_pkg::RST_DMA_ADDR;
            state_ff.fsm <= tdp_pkg::ST_IDLE;
        end
        else if (ce)
        begin
            state_ff <= nxt_state;
        end
    end

    assign prdata = state_ff.prdata;
    assign pready = state_ff.pready;
    assign pslverr = state_ff.pslverr;
    assign timer_input_a = state_ff.tin_a;
    assign onchip_event = state_ff.onchip_evt;
    assign capture_source_port = state_ff.timer_irq_dma_control[tdp_pkg::CAPTURE_SOURCE_SELECT_BIT];
    assign compare_dest_port = state_ff.timer_irq_dma_control[tdp_pkg::COMPARE_DEST_SELECT_BIT];
    assign mem_req = state_ff.mem_req;
    assign mem_we = state_ff.mem_we;
    assign mem_addr = state_ff.mem_addr;
    assign mem_wdata = state_ff.mem_wdata;
    assign port_out = state_ff.slave;
    assign port_oe = {8{state_ff.port_oe}};

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn || !ce);

    sequence s_fetch_done;
        state_ff.fsm == tdp_pkg::ST_READ && mem_ack;
    endsequence

    sequence s_apb_access;
        psel && penable && !state_ff.pready;
    endsequence

    chk_single_byte: assert property (
        state_ff.mem_req && mem_ack |=> !state_ff.mem_req && state_ff.fsm == tdp_pkg::ST_IDLE
    ) else $error("port transfer moved more than one byte");

    chk_cmp_outward: assert property (
        state_ff.mem_req && state_ff.chan_cmp |-> !state_ff.mem_we
    ) else $error("comparator channel wrote into memory");

    chk_cap_direction: assert property (
        $rose(state_ff.mem_req) && !state_ff.chan_cmp |-> state_ff.mem_we == $past(cap_in)
    ) else $error("capture direction differs from port control");

    chk_loop_input: assert property (
        loop_sel |=> state_ff.tin_a == $past(timer_output_a)
    ) else $error("looped input does not follow output A");

    chk_event_strobe: assert property (
        strobe_evt && onchip_now && !(state_ff.fsm == tdp_pkg::ST_READ && mem_ack)
            |=> state_ff.slave == $past(state_ff.master)
    ) else $error("on-chip event did not strobe the port");

    chk_sync_strobe: assert property (
        s_fetch_done and !strobe_evt |=> port_out == $past(mem_rdata)
    ) else $error("internal sync strobe did not update the port");

    chk_match_event: assert property (
        cmp_match && state_ff.output_a_control[tdp_pkg::MATCH_EVENT_ENABLE_BIT] |=> onchip_event
    ) else $error("enabled match did not raise the on-chip event");

    chk_wrap_event: assert property (
        !cmp_match && !(cmp_wrap && state_ff.output_b_control[tdp_pkg::WRAP_EVENT_ENABLE_BIT]) |=> !onchip_event
    ) else $error("on-chip event without an enabled cause");

    chk_disabled_idle: assert property (
        !dma_on && state_ff.fsm == tdp_pkg::ST_IDLE |=> !state_ff.mem_req
    ) else $error("port DMA ran while disabled");

    chk_apb_answer: assert property (
        s_apb_access |=> pready ##1 !pready
    ) else $error("APB answer not one cycle after access");
endmodule
`default_nettype wire

/* dv/tdp_port_dev.sv */
`timescale 1ns/1ns
`default_nettype none
module tdp_port_dev (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Memory side.
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [15:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata,
    output logic mem_ack,
    input wire logic [3:0] ack_dly,
    // Port pins.
    input wire logic [7:0] port_out,
    input wire logic [7:0] port_oe,
    input wire logic [7:0] dev_byte,
    output logic [7:0] port_in
);
    logic [7:0] mem [0:255];
    logic [3:0] cnt;

    // A driven port reads back inverted, so a stale level never passes for fresh data.
    assign port_in = (port_oe[0] === 1'b1) ? ~port_out : dev_byte;

    initial
    begin
        for (int i = 0; i < 256; i++)
        begin
            mem[i] = 8'(i) ^ 8'h5A;
        end
    end

    // Read data toggles outside the acknowledge cycle so that it is never held by accident.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mem_ack <= 1'b0;
            mem_rdata <= 8'h00;
            cnt <= 4'h0;
        end
        else if (mem_ack)
        begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            cnt <= 4'h0;
        end
        else if (mem_req && cnt == ack_dly)
        begin
            mem_ack <= 1'b1;
            mem_rdata <= mem[mem_addr[7:0]];
            if (mem_we)
                mem[mem_addr[7:0]] <= mem_wdata;
        end
        else
        begin
            mem_rdata <= ~mem_rdata;
            if (mem_req)
                cnt <= cnt + 4'h1;
        end
    end
endmodule
`default_nettype wire

/* dv/tdp_timer_dma_port_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tdp_timer_dma_port_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [3:0] pstrb, ack_dly;
    logic cmp_match, cmp_wrap, cmp_dma_req, cap_sw_req, tmr_out_a, pin_a, tmr_in_a, onchip_event;
    logic cap_src, cmp_dst, mem_req, mem_we, mem_ack;
    logic [15:0] mem_addr, ea;
    logic [7:0] mem_wdata, mem_rdata, port_in, port_out, port_oe, dev_byte, old;
    int n_mismatch, tests_run;

    tdp_timer_dma_port #(.PADDR_W(12), .TIMER_INDEX(1)) i_dut (
        .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cmp_match(cmp_match), .cmp_wrap(cmp_wrap),
        .cmp_dma_req(cmp_dma_req), .cap_sw_req(cap_sw_req), .timer_output_a(tmr_out_a),
        .timer_input_a(tmr_in_a), .onchip_event(onchip_event),
        .capture_source_port(cap_src), .compare_dest_port(cmp_dst), .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .mem_ack(mem_ack), .timer_input_a_pin(pin_a),
        .port_in(port_in), .port_out(port_out), .port_oe(port_oe));

    tdp_port_dev i_dev (
        .pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
        .mem_ack(mem_ack), .ack_dly(ack_dly), .port_out(port_out), .port_oe(port_oe),
        .dev_byte(dev_byte), .port_in(port_in));

    initial
        pclk = 1'b0;
    always #25 pclk = ~pclk;

    function automatic logic [7:0] mem_byte(input logic [15:0] a);
        return a[7:0] ^ 8'h5A;
    endfunction

    task automatic finish_test;
        if (n_mismatch == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk32({31'h0, got}, {31'h0, exp});
    endtask

    // The request is held until pready is seen high at a rising edge.
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= 12'({idx, 2'b00});
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20)
        begin
            n_mismatch++;
            finish_test();
        end
    endtask

    task automatic wr_reg(input logic [7:0] idx, input logic [15:0] d);
        apb(1'b1, idx, {16'h0, d});
        repeat (2) @(posedge pclk);
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        chk32(rdat, exp);
    endtask

    task automatic pulse(input int k);
        @(posedge pclk);
        case (k)
            0: cmp_match <= 1'b1;
            1: cmp_wrap <= 1'b1;
            2: cmp_dma_req <= 1'b1;
            default: cap_sw_req <= 1'b1;
        endcase
        @(posedge pclk);
        cmp_match <= 1'b0;
        cmp_wrap <= 1'b0;
        cmp_dma_req <= 1'b0;
        cap_sw_req <= 1'b0;
    endtask

    task automatic ev_chk(input int k, input logic exp);
        pulse(k);
        @(posedge pclk);
        chk1(onchip_event, exp);
    endtask

    task automatic wait_lvl(input logic v);
        int n;
        n = 0;
        while (mem_req !== v && n < 30)
        begin
            @(posedge pclk);
            n++;
        end
        if (n >= 30)
        begin
            n_mismatch++;
            finish_test();
        end
    endtask

    task automatic dma_chk(input logic we, input logic sync);
        wait_lvl(1'b1);
        chk1(mem_we, we);
        chk32({16'h0, mem_addr}, {16'h0, ea});
        chk32({24'h0, port_oe}, we ? 32'h0 : 32'hFF);
        if (we)
            chk32({24'h0, mem_wdata}, {24'h0, dev_byte});
        wait_lvl(1'b0);
        if (!we && sync)
            chk32({24'h0, port_out}, {24'h0, mem_byte(ea)});
        ea = ea + 16'h1;
    endtask

    initial
    begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        finish_test();
    end

    initial
    begin
        {psel, penable, pwrite, cmp_match, cmp_wrap, cmp_dma_req, cap_sw_req} = '0;
        {tmr_out_a, pin_a} = '0;
        paddr = '0;
        pwdata = '0;
        pstrb = 4'hF;
        dev_byte = 8'hC3;
        ack_dly = 4'h0;
        presetn = 1'b0;
        n_mismatch = 0;
        tests_run = 0;
        ea = 16'h0010;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(tdp_pkg::IDX_IRQ_DMA_CTRL, 32'h000000A7);
        rd_chk(tdp_pkg::IDX_IO_CONN, 32'h0);
        rd_chk(tdp_pkg::IDX_OUT_A_CTRL, 32'h0);
        rd_chk(tdp_pkg::IDX_PORT_HS_DMA, 32'h000000FF);
        chk1(cmp_dst, 1'b0);
        apb(1'b0, 8'h00, 32'h0);
        chk1(err, 1'b1);
        wr_reg(tdp_pkg::IDX_IRQ_DMA_CTRL, 16'h0087);
        chk1(cap_src, 1'b0);
        chk1(cmp_dst, 1'b0);
        wr_reg(tdp_pkg::IDX_IRQ_DMA_CTRL, 16'h00B7);
        chk1(cap_src, 1'b1);
        chk1(cmp_dst, 1'b1);
        wr_reg(tdp_pkg::IDX_OUT_A_CTRL, 16'h0002);
        ev_chk(0, 1'b1);
        ev_chk(1, 1'b0);
        wr_reg(tdp_pkg::IDX_OUT_B_CTRL, 16'h0002);
        ev_chk(1, 1'b1);
        wr_reg(tdp_pkg::IDX_OUT_A_CTRL, 16'h0000);
        ev_chk(0, 1'b0);
        tmr_out_a <= 1'b1;
        wr_reg(tdp_pkg::IDX_IO_CONN, 16'h0001);
        repeat (4) @(posedge pclk);
        chk1(tmr_in_a, 1'b0);
        wr_reg(tdp_pkg::IDX_IO_CONN, 16'h0002);
        repeat (4) @(posedge pclk);
        chk1(tmr_in_a, 1'b1);
        wr_reg(tdp_pkg::IDX_IO_CONN, 16'h0000);
        tmr_out_a <= 1'b0;
        pin_a <= 1'b1;
        repeat (4) @(posedge pclk);
        chk1(tmr_in_a, 1'b1);
        pin_a <= 1'b0;
        chk1(mem_req, 1'b0);
        wr_reg(tdp_pkg::IDX_DMA_ADDR, 16'h0010);
        wr_reg(tdp_pkg::IDX_PORT_HS_DMA, 16'h00EA);
        pulse(2);
        dma_chk(1'b0, 1'b1);
        ack_dly <= 4'h3;
        pulse(2);
        dma_chk(1'b0, 1'b1);
        old = port_out;
        wr_reg(tdp_pkg::IDX_PORT_HS_DMA, 16'h00EE);
        wr_reg(tdp_pkg::IDX_OUT_A_CTRL, 16'h0002);
        pulse(2);
        dma_chk(1'b0, 1'b0);
        chk32({24'h0, port_out}, {24'h0, old});
        pulse(0);
        repeat (2) @(posedge pclk);
        chk32({24'h0, port_out}, {24'h0, mem_byte(ea - 16'h1)});
        wr_reg(tdp_pkg::IDX_OUT_A_CTRL, 16'h0000);
        wr_reg(tdp_pkg::IDX_PORT_HS_DMA, 16'h00E8);
        rd_chk(tdp_pkg::IDX_PORT_HS_DMA, 32'h000000E8);
        ack_dly <= 4'h2;
        pulse(3);
        dma_chk(1'b1, 1'b1);
        wr_reg(tdp_pkg::IDX_IO_CONN, 16'h0002);
        wr_reg(tdp_pkg::IDX_PORT_HS_DMA, 16'h00E0);
        tmr_out_a <= 1'b1;
        dma_chk(1'b0, 1'b1);
        wr_reg(tdp_pkg::IDX_PORT_HS_DMA, 16'h00FF);
        pulse(2);
        repeat (6) @(posedge pclk);
        chk1(mem_req, 1'b0);
        finish_test();
    end
endmodule
`default_nettype wire
